// ===== design/typeb_atqb_attrib_handler.sv
`timescale 1ns/1ps
`default_nettype none
module typeb_atqb_attrib_handler #(
    parameter logic [31:0] PUPI = 32'h00000000,
    parameter logic [3:0]  FWI  = 4'h8
) (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       nrst,
    // received bytes from the frame decoder
    input  wire logic [7:0] rx_data,
    input  wire logic       rx_valid,
    input  wire logic       rx_end,
    // transmit byte stream
    output logic      [7:0] tx_data,
    output logic            tx_valid,
    output logic            tx_last,
    input  wire logic       tx_ready,
    // decoded state
    output logic            active_q,
    output logic      [1:0] tr0_code_q,
    output logic      [1:0] tr1_code_q,
    output logic      [7:0] tr0_fs_q,
    output logic      [7:0] tr1_fs_q,
    output logic            send_sof_q,
    output logic            send_eof_q
);
    typedef enum logic [1:0] {
        ST_RX   = 2'b00,
        ST_TX   = 2'b01,
        ST_CRC  = 2'b10
    } state_t;

    state_t      state_q;
    logic [3:0]  rx_cnt_q;
    logic [7:0]  cmd_q;
    logic [7:0]  param1_q;
    logic [15:0] rx_crc_q;
    logic [15:0] tx_crc_q;
    logic [3:0]  tx_idx_q;
    logic [15:0] rx_crc_next;
    logic [15:0] tx_crc_next;
    logic [7:0]  atq_byte;
    logic [7:0]  tx_byte;
    logic        crc_ok;
    logic        is_req;
    logic        is_att;
    logic        rate_ok;
    logic [1:0]  p1_tr0;
    logic [1:0]  p1_tr1;
    logic        rate_ok_q;
    logic        rate_byte_ok;

    function automatic logic [1:0] clean_delay(input logic [1:0] code);
        clean_delay = (code == typeb_pkg::DLY_RESERVED) ?
                      typeb_pkg::DLY_DEFAULT : code;
    endfunction : clean_delay

    crc_b_byte u_rx_crc (
        .crc_in  (rx_crc_q),
        .data_in (rx_data),
        .crc_out (rx_crc_next)
    );
    crc_b_byte u_tx_crc (
        .crc_in  (tx_crc_q),
        .data_in (atq_byte),
        .crc_out (tx_crc_next)
    );

    // answer frame contents
    always_comb begin
        unique case (tx_idx_q)
            4'd0:    atq_byte = typeb_pkg::RSP_ATQ_CODE;
            4'd1:    atq_byte = PUPI[31:24];
            4'd2:    atq_byte = PUPI[23:16];
            4'd3:    atq_byte = PUPI[15:8];
            4'd4:    atq_byte = PUPI[7:0];
            4'd9:    atq_byte = typeb_pkg::PROTO_RATE;
            4'd10:   atq_byte = {typeb_pkg::MAX_FRAME_CODE,
                                 typeb_pkg::PROTO_TYPE};
            4'd11:   atq_byte = {FWI, typeb_pkg::ADC_PROPRIETARY,
                                 typeb_pkg::FO_NONE};
            default: atq_byte = typeb_pkg::APP_DATA_BYTE;
        endcase
    end

    // crc sent low byte first, ones complement
    assign tx_byte = (state_q == ST_CRC) ?
                     (tx_idx_q[0] ? ~tx_crc_q[15:8] : ~tx_crc_q[7:0]) :
                     atq_byte;

    assign crc_ok  = (rx_crc_q == typeb_pkg::CRC_RESIDUE);
    assign is_req  = (cmd_q == typeb_pkg::CMD_REQ_WAKE)
                     && (rx_cnt_q == 4'd5);
    assign is_att  = (cmd_q == typeb_pkg::CMD_ATTACH)
                     && (rx_cnt_q == 4'(typeb_pkg::ATT_LEN));
    // param2 rate fields: equal and each 106k or 212k
    assign rate_ok = rate_ok_q;
    assign p1_tr0  = clean_delay(param1_q[typeb_pkg::P1_TR0_HI:
                                          typeb_pkg::P1_TR0_LO]);
    assign p1_tr1  = clean_delay(param1_q[typeb_pkg::P1_TR1_HI:
                                          typeb_pkg::P1_TR1_LO]);

    assign rate_byte_ok = (rx_data[7:6] == rx_data[5:4]) && !rx_data[7]
                          && !rx_data[5];

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state_q  <= ST_RX;
            rx_cnt_q <= 4'h0;
            cmd_q    <= 8'h00;
            param1_q <= 8'h00;
            rate_ok_q <= 1'b0;
            rx_crc_q <= typeb_pkg::CRC_INIT;
        end else if (state_q == ST_RX && rx_end) begin
            rx_cnt_q <= 4'h0;
            rx_crc_q <= typeb_pkg::CRC_INIT;
            if (crc_ok && is_req) begin
                state_q <= ST_TX;
            end
        end else if (state_q == ST_RX && rx_valid) begin
            rx_crc_q <= rx_crc_next;
            if (rx_cnt_q != 4'hf) begin
                rx_cnt_q <= rx_cnt_q + 4'h1;
            end
            if (rx_cnt_q == 4'h0) begin
                cmd_q <= rx_data;
            end
            if (rx_cnt_q == 4'(typeb_pkg::ATT_PARAM1_IX)) begin
                param1_q <= rx_data;
            end
            if (rx_cnt_q == 4'(typeb_pkg::ATT_PARAM2_IX)) begin
                rate_ok_q <= rate_byte_ok;
            end
        end else if (state_q == ST_CRC && tx_ready
                     && tx_idx_q[0]) begin
            state_q <= ST_RX;
        end else if (state_q == ST_TX && tx_ready
                     && tx_idx_q == 4'(typeb_pkg::ATQ_LEN - 3)) begin
            state_q <= ST_CRC;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst || state_q == ST_RX) begin
            tx_idx_q <= 4'h0;
            tx_crc_q <= typeb_pkg::CRC_INIT;
        end else if (tx_ready) begin
            tx_crc_q <= (state_q == ST_TX) ? tx_crc_next : tx_crc_q;
            tx_idx_q <= (state_q == ST_TX && tx_idx_q ==
                         4'(typeb_pkg::ATQ_LEN - 3)) ? 4'h0 :
                        tx_idx_q + 4'h1;
        end
    end

    // answer stream registered; one byte per ready cycle
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            tx_data  <= 8'h00;
            tx_valid <= 1'b0;
            tx_last  <= 1'b0;
        end else begin
            tx_data  <= tx_byte;
            tx_valid <= (state_q != ST_RX) && tx_ready;
            tx_last  <= (state_q == ST_CRC) && tx_ready && tx_idx_q[0];
        end
    end

    // attach accepted only with good crc and supported rates
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            active_q   <= 1'b0;
            tr0_code_q <= typeb_pkg::DLY_DEFAULT;
            tr1_code_q <= typeb_pkg::DLY_DEFAULT;
            tr0_fs_q   <= typeb_pkg::TR0_FS;
            tr1_fs_q   <= typeb_pkg::TR1_FS;
            send_sof_q <= 1'b1;
            send_eof_q <= 1'b1;
        end else if (state_q == ST_RX && rx_end && crc_ok && is_att
                     && rate_ok) begin
            active_q   <= 1'b1;
            tr0_code_q <= p1_tr0;
            tr1_code_q <= p1_tr1;
            // device timing is fixed regardless of request
            tr0_fs_q   <= typeb_pkg::TR0_FS;
            tr1_fs_q   <= typeb_pkg::TR1_FS;
            send_sof_q <= 1'b1;
            send_eof_q <= 1'b1;
        end
    end

    // answer steps; ready may drop right after the request ends
    sequence s_req_seen;
        state_q == ST_RX && rx_end && crc_ok && is_req;
    endsequence : s_req_seen
    sequence s_atq_first;
        tx_valid && tx_data == typeb_pkg::RSP_ATQ_CODE;
    endsequence : s_atq_first
    sequence s_rate_seen;
        tx_valid && tx_data == typeb_pkg::PROTO_RATE;
    endsequence : s_rate_seen

    a_sof_kept: assert property (@(posedge mclk)
        disable iff (!nrst) send_sof_q && send_eof_q)
        else $error("delimiter omission seen");
    a_tr_fixed: assert property (@(posedge mclk)
        disable iff (!nrst)
        tr0_fs_q == typeb_pkg::TR0_FS && tr1_fs_q == typeb_pkg::TR1_FS)
        else $error("response delay not fixed");
    a_no_resv_code: assert property (@(posedge mclk)
        disable iff (!nrst)
        tr0_code_q != typeb_pkg::DLY_RESERVED
        && tr1_code_q != typeb_pkg::DLY_RESERVED)
        else $error("reserved delay code stored");
    // keyed on the first slot, a crc byte may equal the answer code
    a_rate_byte: assert property (@(posedge mclk)
        disable iff (!nrst)
        (state_q == ST_TX && tx_idx_q == 4'h0 && tx_ready) |=>
        s_atq_first ##[1:20] s_rate_seen)
        else $error("rate byte missing");
    a_att_bad: assert property (@(posedge mclk)
        disable iff (!nrst)
        (state_q == ST_RX && rx_end && !crc_ok) |=>
        $stable(active_q) && state_q == ST_RX)
        else $error("bad crc frame acted on");
    a_att_rate: assert property (@(posedge mclk)
        disable iff (!nrst)
        (state_q == ST_RX && rx_end && is_att && !rate_ok_q) |=>
        $stable(active_q))
        else $error("unsupported rate accepted");
    a_att_go: assert property (@(posedge mclk)
        disable iff (!nrst)
        (state_q == ST_RX && rx_end && crc_ok && is_att && rate_ok) |=>
        active_q)
        else $error("attach not accepted");
    a_req_answer: assert property (@(posedge mclk)
        disable iff (!nrst)
        s_req_seen ##1 tx_ready |=> s_atq_first)
        else $error("no answer start");
endmodule : typeb_atqb_attrib_handler
`default_nettype wire

// ===== design/typeb_pkg.sv
package typeb_pkg;
    // frame codes
    localparam logic [7:0] CMD_REQ_WAKE   = 8'h05;
    localparam logic [7:0] CMD_ATTACH     = 8'h1d;
    localparam logic [7:0] RSP_ATQ_CODE   = 8'h50;
    localparam logic [7:0] APP_DATA_BYTE  = 8'h00;
    localparam logic [7:0] PROTO_RATE     = 8'h91;
    localparam logic [3:0] MAX_FRAME_CODE = 4'h8;
    localparam logic [3:0] PROTO_TYPE     = 4'h1;
    localparam logic [1:0] ADC_PROPRIETARY = 2'h0;
    localparam logic [1:0] FO_NONE        = 2'h0;
    // answer and attach frame layout
    localparam int         ATQ_LEN        = 14;
    localparam int         ATT_LEN        = 11;
    localparam int         ATT_PARAM1_IX  = 5;
    localparam int         ATT_PARAM2_IX  = 6;
    // param1 fields
    localparam int         P1_TR0_HI      = 7;
    localparam int         P1_TR0_LO      = 6;
    localparam int         P1_TR1_HI      = 5;
    localparam int         P1_TR1_LO      = 4;
    localparam int         P1_EOF_BIT     = 3;
    localparam int         P1_SOF_BIT     = 2;
    localparam logic [1:0] DLY_RESERVED   = 2'h3;
    localparam logic [1:0] DLY_DEFAULT    = 2'h0;
    // response delays in subcarrier periods
    localparam logic [7:0] TR0_FS         = 8'h40;
    localparam logic [7:0] TR1_FS         = 8'h50;
    // crc_b
    localparam logic [15:0] CRC_INIT      = 16'hffff;
    localparam logic [15:0] CRC_POLY_REF  = 16'h8408;
    localparam logic [15:0] CRC_RESIDUE   = 16'hf0b8;
    localparam logic [4:0]  CRC_BYTES     = 5'h02;
endpackage : typeb_pkg

// ===== design/crc_b_byte.sv
`timescale 1ns/1ps
`default_nettype none
module crc_b_byte (
    // running value and next byte
    input  wire logic [15:0] crc_in,
    input  wire logic [7:0]  data_in,
    // updated value
    output logic      [15:0] crc_out
);
    logic [15:0] stage [0:8];
    assign stage[0] = crc_in ^ {8'h00, data_in};
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_bit
            assign stage[i+1] = stage[i][0] ?
                ((stage[i] >> 1) ^ typeb_pkg::CRC_POLY_REF) : (stage[i] >> 1);
        end
    endgenerate
    assign crc_out = stage[8];
endmodule : crc_b_byte
`default_nettype wire

// ===== sim/reader_model.sv
`timescale 1ns/1ps
`default_nettype none
module reader_model (
    // clock
    input  wire logic       mclk,
    // frame to the tag
    output logic      [7:0] rx_data,
    output logic            rx_valid,
    output logic            rx_end,
    // answer from the tag
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    input  wire logic       tx_last,
    output logic            tx_ready
);
    // quiet time after an answer, 10 etu plus 32/fs at 50 ns
    localparam int GAP = 2700;
    logic [8:0] got [$];
    bit         slow;
    initial begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
        rx_end = 1'b0;
        tx_ready = 1'b1;
    end
    // slow mode stalls every other cycle
    always @(posedge mclk) begin
        tx_ready <= slow ? ~tx_ready : 1'b1;
        // tx_valid is a per-byte strobe, ready already applied
        if (tx_valid === 1'b1)
            got.push_back({tx_last, tx_data});
    end
    function automatic logic [15:0] crc8(input logic [15:0] c,
                                         input logic [7:0]  b);
        c = c ^ {8'h00, b};
        for (int k = 0; k < 8; k++)
            c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
        return c;
    endfunction : crc8
    task automatic send(input logic [7:0] f [16], input int n,
                        input bit bad);
        logic [15:0] c;
        c = typeb_pkg::CRC_INIT;
        repeat (GAP) @(posedge mclk);
        for (int i = 0; i < n; i++)
            c = crc8(c, f[i]);
        c = ~c ^ {15'h0, bad};
        f[n] = c[7:0];
        f[n + 1] = c[15:8];
        for (int i = 0; i < n + 2; i++) begin
            @(posedge mclk);
            rx_data <= f[i];
            rx_valid <= 1'b1;
        end
        @(posedge mclk);
        // released line shows the inverse, never a stale byte
        rx_data <= ~f[n + 1];
        rx_valid <= 1'b0;
        rx_end <= 1'b1;
        @(posedge mclk);
        rx_end <= 1'b0;
    endtask : send
endmodule : reader_model
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    // pupi value is arbitrary
    localparam logic [31:0] PUPI = 32'h1234abcd;
    localparam logic [3:0]  FWI  = 4'h5;
    logic       mclk;
    logic       nrst;
    logic [7:0] rx_data, tx_data, tr0_fs_q, tr1_fs_q;
    logic       rx_valid, rx_end, tx_valid, tx_last, tx_ready;
    logic       active_q, send_sof_q, send_eof_q;
    logic [1:0] tr0_code_q, tr1_code_q;
    logic [7:0] f [16];
    int         bad_count = 0;
    int         check_count = 0;
    typeb_atqb_attrib_handler #(.PUPI(PUPI), .FWI(FWI)) i_dut (
        .mclk(mclk), .nrst(nrst), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_end(rx_end), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
        .active_q(active_q), .tr0_code_q(tr0_code_q),
        .tr1_code_q(tr1_code_q), .tr0_fs_q(tr0_fs_q),
        .tr1_fs_q(tr1_fs_q), .send_sof_q(send_sof_q),
        .send_eof_q(send_eof_q));
    reader_model i_rdr (
        .mclk(mclk), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_end(rx_end), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_last(tx_last), .tx_ready(tx_ready));
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        check_count++;
        if (s !== e) begin
            bad_count++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, s, e);
        end
    endtask : chk
    task automatic wait_ans(input int n);
        int k;
        k = 0;
        while (i_rdr.got.size() < n && k < 80) begin
            @(posedge mclk);
            k++;
        end
        if (i_rdr.got.size() < n) begin
            bad_count++;
            $display("CHECK FAILED at %0t: answer timed out", $time);
            test_done();
        end
        repeat (n == 0 ? 80 : 4) @(posedge mclk);
    endtask : wait_ans
    task automatic attach(input logic [7:0] p1, input logic [7:0] p2,
                          input bit bad);
        f[0] = 8'h1d;
        {f[1], f[2], f[3], f[4]} = PUPI;
        f[5] = p1;
        f[6] = p2;
        f[7] = 8'h01;
        f[8] = 8'h00;
        i_rdr.send(f, 9, bad);
        repeat (3) @(posedge mclk);
    endtask : attach
    task automatic t_atq(input bit slow, input logic [7:0] prm);
        logic [7:0]  e [12];
        logic [15:0] c;
        e = '{8'h50, PUPI[31:24], PUPI[23:16], PUPI[15:8], PUPI[7:0],
              8'h00, 8'h00, 8'h00, 8'h00, 8'h91, 8'h81, {FWI, 4'h0}};
        i_rdr.slow = slow;
        i_rdr.got.delete();
        f[0] = 8'h05;
        f[1] = 8'h00;
        f[2] = prm;
        i_rdr.send(f, 3, 1'b0);
        wait_ans(14);
        chk(16'(i_rdr.got.size()), 16'h000e);
        c = typeb_pkg::CRC_INIT;
        foreach (i_rdr.got[i]) begin
            c = i_rdr.crc8(c, i_rdr.got[i][7:0]);
            chk(16'(i_rdr.got[i][8]), 16'(i == 13));
        end
        for (int i = 0; i < 12; i++)
            chk(16'(i_rdr.got[i][7:0]), 16'(e[i]));
        chk({i_rdr.got[11][7:4], 4'h0}, {FWI, 4'h0});
        chk(c, 16'hf0b8);
        i_rdr.slow = 1'b0;
    endtask : t_atq
    task automatic t_drop();
        i_rdr.got.delete();
        f[0] = 8'h05;
        i_rdr.send(f, 3, 1'b1);
        wait_ans(0);
        chk(16'(i_rdr.got.size()), 16'h0000);
        attach(8'h00, 8'h08, 1'b1);
        chk(16'(active_q), 16'h0);
        attach(8'h00, 8'h18, 1'b0);
        chk(16'(active_q), 16'h0);
        attach(8'h00, 8'ha8, 1'b0);
        chk(16'(active_q), 16'h0);
    endtask : t_drop
    task automatic t_param();
        logic [1:0] x;
        logic [1:0] y;
        for (int c = 0; c < 4; c++) begin
            x = (c == 3) ? 2'h0 : 2'(c);
            y = (c == 0) ? 2'h0 : 2'(3 - c);
            attach({2'(c), 2'(3 - c), 4'hf}, c[0] ? 8'h58 : 8'h08, 1'b0);
            chk(16'(active_q), 16'h1);
            chk(16'(tr0_code_q), 16'(x));
            chk(16'(tr1_code_q), 16'(y));
            chk({tr0_fs_q, tr1_fs_q}, 16'h4050);
            chk({14'h0, send_sof_q, send_eof_q}, 16'h0003);
        end
    endtask : t_param
    initial begin
        nrst = 1'b0;
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        #1;
        chk(16'(active_q), 16'h0);
        t_atq(1'b0, 8'h00);
        t_atq(1'b1, 8'h08);
        t_drop();
        t_param();
        test_done();
    end
endmodule : tb
`default_nettype wire
